// ### design/clkpath_pkg.sv
package clkpath_pkg;

  // register indices; each register is one aligned word, byte address = index * 4
  localparam logic [11:0] ALIGN_CTRL_IDX    = 12'h10a;  // divider sysref align control index
  localparam logic [11:0] DELAY_MODE_IDX    = 12'h110;  // sample clock delay mode index
  localparam logic [11:0] SFINE_STEP_IDX    = 12'h111;  // super-fine step count index
  localparam logic [11:0] FINE_STEP_IDX     = 12'h112;  // fine step count index
  localparam logic [11:0] PHASE_OFS_IDX     = 12'h109;  // divider phase offset index
  localparam logic [13:0] ALIGN_CTRL_ADDR   = {ALIGN_CTRL_IDX, 2'b00};
  localparam logic [13:0] DELAY_MODE_ADDR   = {DELAY_MODE_IDX, 2'b00};
  localparam logic [13:0] SFINE_STEP_ADDR   = {SFINE_STEP_IDX, 2'b00};
  localparam logic [13:0] FINE_STEP_ADDR    = {FINE_STEP_IDX, 2'b00};
  localparam logic [13:0] PHASE_OFS_ADDR    = {PHASE_OFS_IDX, 2'b00};

  // field positions
  localparam int AUTOPHASE_BIT = 7;  // autophase enable
  localparam int NEG_WIN_LSB   = 2;  // negative skew window [3:2]
  localparam int POS_WIN_LSB   = 0;  // positive skew window [1:0]

  // reset values
  localparam logic [7:0] ALIGN_CTRL_RST = 8'h00;
  localparam logic [7:0] DELAY_MODE_RST = 8'h00;
  localparam logic [7:0] SFINE_STEP_RST = 8'h00;
  localparam logic [7:0] FINE_STEP_RST  = 8'hc0;
  localparam logic [3:0] PHASE_OFS_RST  = 4'h0;

  // writable masks
  localparam logic [7:0] ALIGN_CTRL_WMASK = 8'h8f;
  localparam logic [7:0] DELAY_MODE_WMASK = 8'h07;

  // step limits and sizes in femtoseconds
  localparam logic [7:0] FINE_LIMITED_MAX = 8'h10;  // 16 steps
  localparam logic [7:0] FINE_FULL_MAX    = 8'hc0;  // 192 steps
  localparam logic [7:0] SFINE_FULL_MAX   = 8'h80;  // 128 steps
  localparam int FINE_STEP_FS  = 1725;  // 1.725 ps
  localparam int SFINE_STEP_FS = 250;   // 0.25 ps

  // delay modes
  typedef enum logic [2:0] {
    DLY_NONE      = 3'h0,
    DLY_RSVD      = 3'h1,
    DLY_FINE_LIM  = 3'h2,
    DLY_FINE_LOWJ = 3'h3,
    DLY_FINE_FULL = 3'h4,
    DLY_FINE_ALT  = 3'h5,
    DLY_FINE_SUP  = 3'h6,
    DLY_RSVD7     = 3'h7
  } delay_mode_t;

  // clock path settings carried to the analog side
  typedef struct packed {
    logic        fineEn;      // fine delay line active
    logic        lowJitter;   // lowest-jitter fine configuration
    logic        superEn;     // super-fine delay active
    logic [7:0]  fineSteps;   // applied fine steps
    logic [7:0]  superSteps;  // applied super-fine steps
    logic [18:0] delayFs;     // total applied delay in fs
  } delay_ctrl_t;

  // divider phase state
  typedef struct packed {
    logic        invert;      // half-cycle part (invert clock)
    logic [2:0]  wholeCycles; // whole input cycles of delay
    logic [3:0]  halfCycles;  // total delay in half cycles
  } phase_ctrl_t;

endpackage : clkpath_pkg

// ### design/sysref_align.sv
`timescale 1ns/1ps
// sysref realignment of the divider phase with skew windows
module sysref_align
  import clkpath_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // settings
  input  wire logic       autoEn,
  input  wire logic [1:0] negWin,
  input  wire logic [1:0] posWin,
  input  wire logic [3:0] phaseCode,
  // synchronised sysref level
  input  wire logic       sysrefLvl,
  // results
  output logic            alignPulse,
  output logic [3:0]      phaseNow
);

  logic       sysrefPrev;  // previous sysref sample
  logic [3:0] phaseCnt;    // divider phase counter in half cycles

  // rising sysref edge detection
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sysrefPrev <= 1'b0;
    else
      sysrefPrev <= sysrefLvl;
  end

  // divider phase runs freely; sysref snaps it to the code when it lies outside the window
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phaseCnt   <= 4'h0;
      alignPulse <= 1'b0;
    end
    else
    begin
      alignPulse <= 1'b0;
      phaseCnt   <= phaseCnt + 4'h2;
      if (autoEn && sysrefLvl && !sysrefPrev)
      begin
        // realign only when the current phase lies outside the tolerated window
        if (!inWindow(phaseCnt, phaseCode, negWin, posWin))
        begin
          phaseCnt   <= phaseCode + 4'h2;
          alignPulse <= 1'b1;
        end
      end
    end
  end

  // window check in half device clocks; code 00 demands an exact hit
  function automatic logic inWindow(input logic [3:0] cur, input logic [3:0] tgt,
                                    input logic [1:0] neg, input logic [1:0] pos);
    logic [3:0] early;
    logic [3:0] late;
    early = tgt - cur;
    late  = cur - tgt;
    inWindow = (cur == tgt) || (early <= {2'b00, neg}) || (late <= {2'b00, pos});
  endfunction : inWindow

  assign phaseNow = phaseCnt;

endmodule : sysref_align

// ### design/clock_path_ctrl.sv
`timescale 1ns/1ps
// Operation
// - codes 1000-1111 delay four to seven and half
// - codes 0000-0111 delay zero to three and half
// - autophase bit enables sysref divider realignment
// - bits 3:2 set early sysref tolerance
// - bits 1:0 set late sysref tolerance
// - mode 000 bypasses delay; 001 reserved
// - modes 010/011 fine steps 0-16 only
// - mode 100 and 101 full fine range
// - mode 110 fine plus super-fine full
// - fine step equals 1.725 ps
// - super-fine step equals 0.25 ps
module clock_path_ctrl
  import clkpath_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [13:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // sysref pin
  input  wire logic                   sysref,
  // clock path controls
  output clkpath_pkg::delay_ctrl_t    delayCtrl,
  output clkpath_pkg::phase_ctrl_t    phaseCtrl,
  output logic                        realignPulse
);

  logic       rstSync1;     // reset release stage one
  logic       rstn;         // synchronised reset
  logic       sysrefMeta;   // sysref stage one
  logic       sysrefSync;   // sysref stage two
  logic [7:0] alignCtrl_q;  // divider sysref align control
  logic [7:0] delayMode_q;  // delay mode select
  logic [7:0] fineStep_q;   // fine step count
  logic [7:0] sfineStep_q;  // super-fine step count
  logic [3:0] phaseOfs_q;   // divider phase offset code
  logic       alignPulse;   // realignment event
  logic [3:0] phaseNow;     // live divider phase
  logic       wrEn;         // apb write access
  logic       rdEn;         // apb read access
  logic       mapped;       // address decodes
  logic [31:0]  rdMux;      // read data selection
  delay_ctrl_t  delay_d;    // next delay controls

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstSync1 <= 1'b0;
      rstn     <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstn     <= rstSync1;
    end
  end

  // sysref pin synchroniser
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sysrefMeta <= 1'b0;
      sysrefSync <= 1'b0;
    end
    else
    begin
      sysrefMeta <= sysref;
      sysrefSync <= sysrefMeta;
    end
  end

  // apb decode: zero-wait access
  assign wrEn   = psel && penable && pwrite;
  assign rdEn   = psel && penable && !pwrite;
  assign mapped = (paddr == ALIGN_CTRL_ADDR) || (paddr == DELAY_MODE_ADDR) ||
                  (paddr == SFINE_STEP_ADDR) || (paddr == FINE_STEP_ADDR) ||
                  (paddr == PHASE_OFS_ADDR);

  // register writes; reserved bits masked away
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      alignCtrl_q <= ALIGN_CTRL_RST;
      delayMode_q <= DELAY_MODE_RST;
      fineStep_q  <= FINE_STEP_RST;
      sfineStep_q <= SFINE_STEP_RST;
      phaseOfs_q  <= PHASE_OFS_RST;
    end
    else if (wrEn && pstrb[0])
    begin
      unique case (paddr)
        ALIGN_CTRL_ADDR: alignCtrl_q <= pwdata[7:0] & ALIGN_CTRL_WMASK;
        DELAY_MODE_ADDR: delayMode_q <= pwdata[7:0] & DELAY_MODE_WMASK;
        FINE_STEP_ADDR:  fineStep_q  <= pwdata[7:0];
        SFINE_STEP_ADDR: sfineStep_q <= pwdata[7:0];
        PHASE_OFS_ADDR:  phaseOfs_q  <= pwdata[3:0];
        default:         ;  // unmapped: ignored
      endcase
    end
  end

  // read mux; upper bits read zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      ALIGN_CTRL_ADDR: rdMux = {24'h00_0000, alignCtrl_q};
      DELAY_MODE_ADDR: rdMux = {24'h00_0000, delayMode_q};
      FINE_STEP_ADDR:  rdMux = {24'h00_0000, fineStep_q};
      SFINE_STEP_ADDR: rdMux = {24'h00_0000, sfineStep_q};
      PHASE_OFS_ADDR:  rdMux = {24'h00_0000, phaseNow, phaseOfs_q};
      default:         rdMux = 32'h0000_0000;
    endcase
  end

  // apb response registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite)
        prdata <= rdMux;
    end
  end

  // clamp a step count to the range a mode allows
  function automatic logic [7:0] clampSteps(input logic [7:0] steps, input logic [7:0] lim);
    clampSteps = (steps > lim) ? lim : steps;
  endfunction : clampSteps

  // delay mode decode
  always_comb
  begin
    delay_d = '0;
    unique case (delay_mode_t'(delayMode_q[2:0]))
      DLY_NONE, DLY_RSVD, DLY_RSVD7:
        delay_d = '0;
      DLY_FINE_LIM, DLY_FINE_LOWJ:
      begin
        delay_d.fineEn    = 1'b1;
        delay_d.lowJitter = (delayMode_q[2:0] == DLY_FINE_LOWJ);
        delay_d.fineSteps = clampSteps(fineStep_q, FINE_LIMITED_MAX);
      end
      DLY_FINE_FULL, DLY_FINE_ALT:
      begin
        delay_d.fineEn    = 1'b1;
        delay_d.fineSteps = clampSteps(fineStep_q, FINE_FULL_MAX);
      end
      DLY_FINE_SUP:
      begin
        delay_d.fineEn     = 1'b1;
        delay_d.superEn    = 1'b1;
        delay_d.fineSteps  = clampSteps(fineStep_q, FINE_FULL_MAX);
        delay_d.superSteps = clampSteps(sfineStep_q, SFINE_FULL_MAX);
      end
    endcase
    delay_d.delayFs = 19'(int'(delay_d.fineSteps) * FINE_STEP_FS +
                          int'(delay_d.superSteps) * SFINE_STEP_FS);
  end

  // registered delay controls
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      delayCtrl <= '0;
    else
      delayCtrl <= delay_d;
  end

  // divider phase offset decode: half cycles, lsb inverts
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phaseCtrl <= '0;
    else
    begin
      phaseCtrl.halfCycles  <= phaseOfs_q;
      phaseCtrl.invert      <= phaseOfs_q[0];
      phaseCtrl.wholeCycles <= phaseOfs_q[3:1];
    end
  end

  // registered realignment event
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      realignPulse <= 1'b0;
    else
      realignPulse <= alignPulse;
  end

  // sysref alignment engine
  sysref_align i_sysref_align (
    .clk        (clk),
    .rstn       (rstn),
    .autoEn     (alignCtrl_q[AUTOPHASE_BIT]),
    .negWin     (alignCtrl_q[NEG_WIN_LSB +: 2]),
    .posWin     (alignCtrl_q[POS_WIN_LSB +: 2]),
    .phaseCode  (phaseOfs_q),
    .sysrefLvl  (sysrefSync),
    .alignPulse (alignPulse),
    .phaseNow   (phaseNow)
  );

endmodule : clock_path_ctrl

// ### tb/clock_path_ctrl_props.sv
`timescale 1ns/1ps
// timing and value relations at the controller ports
module clock_path_ctrl_props
  import clkpath_pkg::*;
(
  // clock and reset
  input wire logic                     clk,
  input wire logic                     resetn,
  // apb
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [13:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [3:0]               pstrb,
  input wire logic                     pready,
  input wire logic [31:0]              prdata,
  input wire logic                     pslverr,
  // clock path
  input wire logic                     sysref,
  input wire clkpath_pkg::delay_ctrl_t delayCtrl,
  input wire clkpath_pkg::phase_ctrl_t phaseCtrl,
  input wire logic                     realignPulse
);
  logic       mapped;  // address hits a register
  logic [3:0] lowCnt;  // quiet sysref cycles, saturating
  assign mapped = paddr inside {ALIGN_CTRL_ADDR, DELAY_MODE_ADDR, SFINE_STEP_ADDR,
                                FINE_STEP_ADDR, PHASE_OFS_ADDR};
  // count cycles since sysref was last high
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lowCnt <= 4'h0;
    else if (sysref)
      lowCnt <= 4'h0;
    else if (lowCnt != 4'hf)
      lowCnt <= lowCnt + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ready_one_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_answer_a: assert property (psel && !penable |=> pready && penable)
    else $error("no answer in access cycle");
  unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("error on mapped address");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  delay_sum_a: assert property (
    32'(delayCtrl.delayFs) == delayCtrl.fineSteps * FINE_STEP_FS
    + delayCtrl.superSteps * SFINE_STEP_FS)
    else $error("delay total wrong");
  fine_limit_a: assert property (
    delayCtrl.lowJitter |-> delayCtrl.fineEn && delayCtrl.fineSteps <= 8'h10)
    else $error("limited fine range exceeded");
  super_both_a: assert property (
    delayCtrl.superEn |-> delayCtrl.fineEn
    && delayCtrl.superSteps <= 8'h80 && delayCtrl.fineSteps <= 8'hc0)
    else $error("super fine without full fine");
  phase_split_a: assert property (
    phaseCtrl.invert == phaseCtrl.halfCycles[0]
    && phaseCtrl.wholeCycles == phaseCtrl.halfCycles[3:1])
    else $error("phase split wrong");
  realign_quiet_a: assert property (lowCnt == 4'hf |-> !realignPulse)
    else $error("realign without sysref");
  cover property (pready && pslverr);
  cover property (realignPulse);
  cover property (delayCtrl.superEn);
endmodule : clock_path_ctrl_props

bind clock_path_ctrl clock_path_ctrl_props i_clock_path_ctrl_props (.clk, .resetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .sysref,
  .delayCtrl, .phaseCtrl, .realignPulse);

// ### tb/sysref_source.sv
`timescale 1ns/1ps
// sysref source: three pulses locked to the device clock
module sysref_source
(
  // device clock
  input wire logic clk,
  // burst start
  input wire logic go,
  // sysref level to the device
  output logic     sysref
);
  initial sysref = 1'b0;
  // edges land just after a clock edge so capture is exact
  always @(posedge clk)
  begin
    if (go)
    begin
      repeat (3)
      begin
        sysref <= 1'b1;
        repeat (4) @(posedge clk);
        sysref <= 1'b0;
        repeat (12) @(posedge clk);
      end
    end
  end
endmodule : sysref_source

// ### tb/clock_path_ctrl_bench.sv
`timescale 1ns/1ps
// register, delay mode, phase and sysref tests
module clock_path_ctrl_bench;
  import clkpath_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        sysref;
  logic        go = 1'b0;     // starts a sysref burst
  delay_ctrl_t delayCtrl;
  phase_ctrl_t phaseCtrl;
  logic        realignPulse;
  logic [7:0]  st;            // step value of a pass
  logic [31:0] rd;            // last read data
  logic        er;            // last error flag
  int          pulses = 0;    // realign pulses seen
  int          fails = 0;
  int          total_checks = 0;
  always #4 clk = ~clk;
  // count realign pulses
  always @(posedge clk)
    if (realignPulse === 1'b1)
      pulses <= pulses + 1;
  clock_path_ctrl i_clock_path_ctrl (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .sysref, .delayCtrl, .phaseCtrl,
    .realignPulse);
  sysref_source i_sysref_source (.clk, .go, .sysref);
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // compares one value
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // reads a register, compares masked data and error flag
  task automatic rdchk(input logic [13:0] a, input logic [31:0] e, input logic [31:0] m,
                       input logic x);
    apb(1'b0, a, 32'h0, 4'h0);
    chk("rdata", {8'h0, e}, {8'h0, rd & m});
    chk("slverr", {39'h0, x}, {39'h0, er});
  endtask : rdchk
  // expected clock path settings for a mode and step counts
  function automatic delay_ctrl_t exp_dly(input logic [2:0] m, input logic [7:0] s);
    delay_ctrl_t r;
    r = '0;
    r.fineEn = m inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    r.lowJitter = (m == 3'h3);
    r.superEn = (m == 3'h6);
    if (m inside {3'h2, 3'h3})
      r.fineSteps = (s > 8'h10) ? 8'h10 : s;
    if (m inside {3'h4, 3'h5, 3'h6})
      r.fineSteps = (s > 8'hc0) ? 8'hc0 : s;
    if (m == 3'h6)
      r.superSteps = (s > 8'h80) ? 8'h80 : s;
    r.delayFs = 19'(r.fineSteps * 1725 + r.superSteps * 250);
    return r;
  endfunction : exp_dly
  // prints counts and verdict, then stops
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // watchdog
  initial
  begin
    #200000;
    fails++;
    final_report;
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(ALIGN_CTRL_ADDR, 32'h00, 32'hffffffff, 1'b0);
    rdchk(DELAY_MODE_ADDR, 32'h00, 32'hffffffff, 1'b0);
    rdchk(FINE_STEP_ADDR, 32'hc0, 32'hffffffff, 1'b0);
    rdchk(SFINE_STEP_ADDR, 32'h00, 32'hffffffff, 1'b0);
    rdchk(PHASE_OFS_ADDR, 32'h00, 32'hffffff0f, 1'b0);
    chk("delay", 40'h0, {2'h0, delayCtrl});
    apb(1'b1, ALIGN_CTRL_ADDR, 32'hffffffff, 4'hf);
    rdchk(ALIGN_CTRL_ADDR, 32'h8f, 32'hffffffff, 1'b0);
    apb(1'b1, ALIGN_CTRL_ADDR, 32'h00, 4'h0);
    rdchk(ALIGN_CTRL_ADDR, 32'h8f, 32'hffffffff, 1'b0);
    apb(1'b1, DELAY_MODE_ADDR, 32'hfc, 4'hf);
    rdchk(DELAY_MODE_ADDR, 32'h04, 32'hffffffff, 1'b0);
    apb(1'b1, 14'h0, 32'hff, 4'hf);
    rdchk(14'h0, 32'h0, 32'hffffffff, 1'b1);
    $display("test registers done");
    for (int p = 0; p < 2; p++)
    begin
      st = p ? 8'hff : 8'h08;
      apb(1'b1, FINE_STEP_ADDR, {24'h0, st}, 4'hf);
      apb(1'b1, SFINE_STEP_ADDR, {24'h0, st}, 4'hf);
      for (int m = 0; m < 8; m++)
      begin
        if (m != 1)
        begin
          apb(1'b1, DELAY_MODE_ADDR, 32'(m), 4'hf);
          repeat (3) @(posedge clk);
          chk("delay", {2'h0, exp_dly(m[2:0], st)}, {2'h0, delayCtrl});
        end
      end
    end
    $display("test delay modes done");
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, PHASE_OFS_ADDR, 32'(c), 4'hf);
      repeat (3) @(posedge clk);
      chk("phase", {32'h0, c[0], c[3:1], c[3:0]}, {32'h0, phaseCtrl});
    end
    $display("test phase codes done");
    apb(1'b1, PHASE_OFS_ADDR, 32'h1, 4'hf);
    for (int e = 0; e < 2; e++)
    begin
      apb(1'b1, ALIGN_CTRL_ADDR, e ? 32'h80 : 32'h0f, 4'hf);
      pulses = 0;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (60) @(posedge clk);
      chk("realign", {39'h0, e[0]}, {39'h0, pulses != 0});
    end
    $display("test sysref done");
    final_report;
  end
endmodule : clock_path_ctrl_bench
